// *** logic/psm_port_mux.sv ***
// port signal multiplexer for ports A to D with AXI4-Lite control registers
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
module psm_port_mux
   import psm_pkg::*;
#(
   parameter bit NEW_MASK = 1'b1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic powerOnResetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] padInA,
   input wire logic [31:0] padInB,
   input wire logic [31:0] padInC,
   input wire logic [31:0] padInD,
   output logic [31:0] padOutA,
   output logic [31:0] padOutB,
   output logic [31:0] padOutC,
   output logic [31:0] padOutD,
   output logic [31:0] padOenA,
   output logic [31:0] padOenB,
   output logic [31:0] padOenC,
   output logic [31:0] padOenD,
   input wire logic [31:0] hwOutA,
   input wire logic [31:0] hwOutB,
   input wire logic [31:0] hwOutC,
   input wire logic [31:0] hwOutD,
   input wire logic [31:0] hwOeA,
   input wire logic [31:0] hwOeB,
   input wire logic [31:0] hwOeC,
   input wire logic [31:0] hwOeD,
   output logic [31:0] hwInA,
   output logic [31:0] hwInB,
   output logic [31:0] hwInC,
   output logic [31:0] hwInD,
   input wire logic altClock,
   output logic [31:0] irqLines,
   output logic nmiLine,
   output logic [3:0] bootSelectStrap,
   output logic hostByteWidthStrap
);
   // per-mask masks
   localparam logic [31:0] IMPL_D = NEW_MASK ? IMPL_D_NEW : IMPL_D_OLD;
   localparam logic [31:0] GP_B = NEW_MASK ? GP_B_NEW : GP_B_OLD;
   localparam logic [31:0] GP_C = NEW_MASK ? GP_C_NEW : GP_C_OLD;
   localparam logic [31:0] GP_D = NEW_MASK ? GP_D_NEW : GP_D_OLD;

   logic rstSync1_ff, rstSync2_ff;
   logic porSync1_ff, porSync2_ff, porSeen_ff;
   logic [31:0] ctlA_ff, ctlB_ff, ctlC_ff, ctlD_ff;
   logic [31:0] dirA_ff, dirB_ff, dirC_ff, dirD_ff;
   logic [31:0] outA_ff, outB_ff, outC_ff, outD_ff;
   logic [31:0] intenA_ff;
   logic [1:0] chipCfg_ff;
   logic [4:0] strap_ff;
   logic [31:0] nxt_ctlA, nxt_ctlB, nxt_ctlC, nxt_ctlD;
   logic [31:0] nxt_dirA, nxt_dirB, nxt_dirC, nxt_dirD;
   logic [31:0] nxt_outA, nxt_outB, nxt_outC, nxt_outD;
   logic [31:0] nxt_intenA;
   logic [1:0] nxt_chipCfg;
   logic [4:0] nxt_strap;
   logic nxt_porSeen;
   psm_wr_t wrState_ff, nxt_wrState;
   logic awHeld_ff, wHeld_ff, nxt_awHeld, nxt_wHeld;
   logic [7:0] awAddr_ff, nxt_awAddr;
   logic [31:0] wData_ff, nxt_wData;
   logic [3:0] wStrb_ff, nxt_wStrb;
   logic bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   logic rvalid_ff, nxt_rvalid;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0] rresp_ff, nxt_rresp;
   logic [31:0] pOutA_ff, pOutB_ff, pOutC_ff, pOutD_ff;
   logic [31:0] pOenA_ff, pOenB_ff, pOenC_ff, pOenD_ff;
   logic [31:0] hInA_ff, hInB_ff, hInC_ff, hInD_ff;
   logic [31:0] irq_ff, inA_ff, inB_ff, inC_ff, inD_ff;
   logic nmi_ff;
   logic [31:0] nxt_pOutA, nxt_pOutB, nxt_pOutC, nxt_pOutD;
   logic [31:0] nxt_pOenA, nxt_pOenB, nxt_pOenC, nxt_pOenD;
   logic [31:0] nxt_hInA, nxt_hInB, nxt_hInC, nxt_hInD;
   logic [31:0] nxt_irq, nxt_inA, nxt_inB, nxt_inC, nxt_inD;
   logic nxt_nmi;
   logic rstn;

   // reset release synchronisers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstSync1_ff <= 1'b0;
         rstSync2_ff <= 1'b0;
      end else begin
         rstSync1_ff <= 1'b1;
         rstSync2_ff <= rstSync1_ff;
      end
   end
   assign rstn = rstSync2_ff;

   // power on reset pin synchroniser
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         porSync1_ff <= 1'b0;
         porSync2_ff <= 1'b0;
      end else begin
         porSync1_ff <= powerOnResetn;
         porSync2_ff <= porSync1_ff;
      end
   end

   // write byte merge
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] strb, input logic [31:0] impl);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      return res & impl;
   endfunction

   // register file and bus next state
   always_comb begin
      logic wrGo;
      logic [31:0] rd;
      logic hit;
      wrGo = 1'b0;
      rd = 32'h0000_0000;
      hit = 1'b1;
      nxt_ctlA = ctlA_ff;
      nxt_ctlB = ctlB_ff;
      nxt_ctlC = ctlC_ff;
      nxt_ctlD = ctlD_ff;
      nxt_dirA = dirA_ff;
      nxt_dirB = dirB_ff;
      nxt_dirC = dirC_ff;
      nxt_dirD = dirD_ff;
      nxt_outA = outA_ff;
      nxt_outB = outB_ff;
      nxt_outC = outC_ff;
      nxt_outD = outD_ff;
      nxt_intenA = intenA_ff;
      nxt_chipCfg = chipCfg_ff;
      nxt_wrState = wrState_ff;
      nxt_awHeld = awHeld_ff;
      nxt_wHeld = wHeld_ff;
      nxt_awAddr = awAddr_ff;
      nxt_wData = wData_ff;
      nxt_wStrb = wStrb_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      // address and data taken in either order
      if (!awHeld_ff && s_axi_awvalid && wrState_ff == WR_IDLE) begin
         nxt_awHeld = 1'b1;
         nxt_awAddr = s_axi_awaddr;
      end
      if (!wHeld_ff && s_axi_wvalid && wrState_ff == WR_IDLE) begin
         nxt_wHeld = 1'b1;
         nxt_wData = s_axi_wdata;
         nxt_wStrb = s_axi_wstrb;
      end
      unique case (wrState_ff)
         WR_IDLE: begin
            if (awHeld_ff && wHeld_ff) begin
               wrGo = 1'b1;
               nxt_awHeld = 1'b0;
               nxt_wHeld = 1'b0;
               nxt_bvalid = 1'b1;
               nxt_wrState = WR_RESP;
            end
         end
         WR_RESP: begin
            if (s_axi_bready) begin
               nxt_bvalid = 1'b0;
               nxt_wrState = WR_IDLE;
            end
         end
      endcase
      if (wrGo) begin
         nxt_bresp = RESP_OKAY;
         unique case ({awAddr_ff[7:2], 2'b00})
            OFF_CTL_A: nxt_ctlA = merge(ctlA_ff, wData_ff, wStrb_ff, IMPL_A);
            OFF_CTL_B: nxt_ctlB = merge(ctlB_ff, wData_ff, wStrb_ff, IMPL_B);
            OFF_CTL_C: nxt_ctlC = merge(ctlC_ff, wData_ff, wStrb_ff, IMPL_C);
            OFF_CTL_D: nxt_ctlD = merge(ctlD_ff, wData_ff, wStrb_ff, IMPL_D);
            OFF_DIR_A: nxt_dirA = merge(dirA_ff, wData_ff, wStrb_ff, IMPL_A);
            OFF_DIR_B: nxt_dirB = merge(dirB_ff, wData_ff, wStrb_ff, IMPL_B);
            OFF_DIR_C: nxt_dirC = merge(dirC_ff, wData_ff, wStrb_ff, IMPL_C);
            OFF_DIR_D: nxt_dirD = merge(dirD_ff, wData_ff, wStrb_ff, IMPL_D);
            OFF_OUT_A: nxt_outA = merge(outA_ff, wData_ff, wStrb_ff, GP_A);
            OFF_OUT_B: nxt_outB = merge(outB_ff, wData_ff, wStrb_ff, GP_B);
            OFF_OUT_C: nxt_outC = merge(outC_ff, wData_ff, wStrb_ff, GP_C);
            OFF_OUT_D: nxt_outD = merge(outD_ff, wData_ff, wStrb_ff, GP_D);
            OFF_INTEN_A: nxt_intenA = merge(intenA_ff, wData_ff, wStrb_ff, IRQ_A);
            OFF_CHIPCFG: begin
               if (wStrb_ff[0]) begin
                  nxt_chipCfg = wData_ff[1:0];
               end
            end
            OFF_IN_A, OFF_IN_B, OFF_IN_C, OFF_IN_D, OFF_STRAP: nxt_bresp = RESP_OKAY;
            default: nxt_bresp = RESP_SLVERR;
         endcase
      end
      // read channel
      unique case ({s_axi_araddr[7:2], 2'b00})
         OFF_CTL_A: rd = ctlA_ff;
         OFF_CTL_B: rd = ctlB_ff;
         OFF_CTL_C: rd = ctlC_ff;
         OFF_CTL_D: rd = ctlD_ff;
         OFF_DIR_A: rd = dirA_ff;
         OFF_DIR_B: rd = dirB_ff;
         OFF_DIR_C: rd = dirC_ff;
         OFF_DIR_D: rd = dirD_ff;
         OFF_OUT_A: rd = outA_ff;
         OFF_OUT_B: rd = outB_ff;
         OFF_OUT_C: rd = outC_ff;
         OFF_OUT_D: rd = outD_ff;
         OFF_IN_A: rd = inA_ff;
         OFF_IN_B: rd = inB_ff;
         OFF_IN_C: rd = inC_ff;
         OFF_IN_D: rd = inD_ff;
         OFF_INTEN_A: rd = intenA_ff;
         OFF_CHIPCFG: rd = {30'h0000_0000, chipCfg_ff};
         OFF_STRAP: rd = {27'h000_0000, strap_ff};
         default: hit = 1'b0;
      endcase
      if (!rvalid_ff && s_axi_arvalid) begin
         nxt_rvalid = 1'b1;
         nxt_rdata = rd;
         nxt_rresp = hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
   end

   // register file and bus flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctlA_ff <= RST_VAL;
         ctlB_ff <= RST_VAL;
         ctlC_ff <= RST_VAL;
         ctlD_ff <= RST_VAL;
         dirA_ff <= RST_VAL;
         dirB_ff <= RST_VAL;
         dirC_ff <= RST_VAL;
         dirD_ff <= RST_VAL;
         outA_ff <= RST_VAL;
         outB_ff <= RST_VAL;
         outC_ff <= RST_VAL;
         outD_ff <= RST_VAL;
         intenA_ff <= RST_VAL;
         chipCfg_ff <= 2'b00;
         wrState_ff <= WR_IDLE;
         awHeld_ff <= 1'b0;
         wHeld_ff <= 1'b0;
         awAddr_ff <= 8'h00;
         wData_ff <= 32'h0000_0000;
         wStrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
      end else begin
         ctlA_ff <= nxt_ctlA;
         ctlB_ff <= nxt_ctlB;
         ctlC_ff <= nxt_ctlC;
         ctlD_ff <= nxt_ctlD;
         dirA_ff <= nxt_dirA;
         dirB_ff <= nxt_dirB;
         dirC_ff <= nxt_dirC;
         dirD_ff <= nxt_dirD;
         outA_ff <= nxt_outA;
         outB_ff <= nxt_outB;
         outC_ff <= nxt_outC;
         outD_ff <= nxt_outD;
         intenA_ff <= nxt_intenA;
         chipCfg_ff <= nxt_chipCfg;
         wrState_ff <= nxt_wrState;
         awHeld_ff <= nxt_awHeld;
         wHeld_ff <= nxt_wHeld;
         awAddr_ff <= nxt_awAddr;
         wData_ff <= nxt_wData;
         wStrb_ff <= nxt_wStrb;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   // strap capture on the rising edge of the synchronised power on reset
   always_comb begin
      nxt_porSeen = porSeen_ff;
      nxt_strap = strap_ff;
      if (porSync2_ff && !porSeen_ff) begin
         nxt_porSeen = 1'b1;
         nxt_strap = {padInD[2], padInD[8] & NEW_MASK, padInD[7] & NEW_MASK,
                      padInC[15], padInC[14]};
      end else if (!porSync2_ff) begin
         nxt_porSeen = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         porSeen_ff <= 1'b0;
         strap_ff <= 5'h00;
      end else begin
         porSeen_ff <= nxt_porSeen;
         strap_ff <= nxt_strap;
      end
   end

   // pin multiplexing, all four ports every cycle
   always_comb begin
      logic [31:0] swOutA, swOutB, swOutC, swOutD;
      logic [31:0] altA, altD;
      logic [31:0] hwA;
      altA = (ctlA_ff & IMPL_A) & {32{chipCfg_ff[CFG_PAS_BIT]}};
      altA = altA & (32'h0000_0001 << CLKOUT_POS);
      altD = (ctlD_ff & IMPL_D) & {32{chipCfg_ff[CFG_PDS_BIT]}} & 32'h0000_0000;
      // hardware lines not taken by alternate function or the nmi line keep primary
      hwA = ctlA_ff & IMPL_A & ~altA & ~(32'h0000_0001 << NMI_POS);
      swOutA = ~ctlA_ff & dirA_ff & GP_A;
      swOutB = ~ctlB_ff & dirB_ff & GP_B;
      swOutC = ~ctlC_ff & dirC_ff & GP_C;
      swOutD = ~ctlD_ff & dirD_ff & GP_D;
      nxt_pOutA = (swOutA & outA_ff) | (hwA & hwOutA) | (altA & {32{altClock}});
      nxt_pOenA = ~(swOutA | (hwA & hwOeA) | altA);
      nxt_pOutB = (swOutB & outB_ff) | (ctlB_ff & IMPL_B & hwOutB);
      nxt_pOenB = ~(swOutB | (ctlB_ff & IMPL_B & hwOeB));
      nxt_pOutC = (swOutC & outC_ff) | (ctlC_ff & IMPL_C & hwOutC);
      nxt_pOenC = ~(swOutC | (ctlC_ff & IMPL_C & hwOeC));
      nxt_pOutD = (swOutD & outD_ff) | (ctlD_ff & IMPL_D & ~altD & hwOutD);
      nxt_pOenD = ~(swOutD | (ctlD_ff & IMPL_D & ~altD & hwOeD));
      nxt_hInA = padInA & hwA;
      nxt_hInB = padInB & ctlB_ff & IMPL_B;
      nxt_hInC = padInC & ctlC_ff & IMPL_C;
      nxt_hInD = padInD & ctlD_ff & IMPL_D & ~altD;
      // interrupt only in software input mode with enable set
      nxt_irq = padInA & intenA_ff & ~ctlA_ff & ~dirA_ff & IRQ_A;
      // general purpose inputs, reserved positions read zero
      nxt_inA = padInA & GP_A & ~ctlA_ff & ~dirA_ff & ~intenA_ff;
      nxt_inB = padInB & GP_B & ~ctlB_ff & ~dirB_ff;
      nxt_inC = padInC & GP_C & ~ctlC_ff & ~dirC_ff;
      nxt_inD = padInD & GP_D & ~ctlD_ff & ~dirD_ff;
      nxt_nmi = padInA[NMI_POS];
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pOutA_ff <= 32'h0000_0000;
         pOutB_ff <= 32'h0000_0000;
         pOutC_ff <= 32'h0000_0000;
         pOutD_ff <= 32'h0000_0000;
         pOenA_ff <= 32'hffff_ffff;
         pOenB_ff <= 32'hffff_ffff;
         pOenC_ff <= 32'hffff_ffff;
         pOenD_ff <= 32'hffff_ffff;
         hInA_ff <= 32'h0000_0000;
         hInB_ff <= 32'h0000_0000;
         hInC_ff <= 32'h0000_0000;
         hInD_ff <= 32'h0000_0000;
         irq_ff <= 32'h0000_0000;
         inA_ff <= 32'h0000_0000;
         inB_ff <= 32'h0000_0000;
         inC_ff <= 32'h0000_0000;
         inD_ff <= 32'h0000_0000;
         nmi_ff <= 1'b0;
      end else begin
         pOutA_ff <= nxt_pOutA;
         pOutB_ff <= nxt_pOutB;
         pOutC_ff <= nxt_pOutC;
         pOutD_ff <= nxt_pOutD;
         pOenA_ff <= nxt_pOenA;
         pOenB_ff <= nxt_pOenB;
         pOenC_ff <= nxt_pOenC;
         pOenD_ff <= nxt_pOenD;
         hInA_ff <= nxt_hInA;
         hInB_ff <= nxt_hInB;
         hInC_ff <= nxt_hInC;
         hInD_ff <= nxt_hInD;
         irq_ff <= nxt_irq;
         inA_ff <= nxt_inA;
         inB_ff <= nxt_inB;
         inC_ff <= nxt_inC;
         inD_ff <= nxt_inD;
         nmi_ff <= nxt_nmi;
      end
   end

   // outputs straight from flops, write ready lines decoded from the held and state flops, read ready from the read valid flop
   assign s_axi_awready = !awHeld_ff && wrState_ff == WR_IDLE;
   assign s_axi_wready = !wHeld_ff && wrState_ff == WR_IDLE;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign padOutA = pOutA_ff;
   assign padOutB = pOutB_ff;
   assign padOutC = pOutC_ff;
   assign padOutD = pOutD_ff;
   assign padOenA = pOenA_ff;
   assign padOenB = pOenB_ff;
   assign padOenC = pOenC_ff;
   assign padOenD = pOenD_ff;
   assign hwInA = hInA_ff;
   assign hwInB = hInB_ff;
   assign hwInC = hInC_ff;
   assign hwInD = hInD_ff;
   assign irqLines = irq_ff;
   assign nmiLine = nmi_ff;
   assign bootSelectStrap = strap_ff[3:0];
   assign hostByteWidthStrap = strap_ff[STRAP_HBW_BIT];
endmodule // psm_port_mux

// *** logic/psm_pkg.sv ***
// constants, register map and line masks for the port signal multiplexer
package psm_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   // register byte offsets
   localparam logic [7:0] OFF_CTL_A = 8'h00;
   localparam logic [7:0] OFF_CTL_B = 8'h04;
   localparam logic [7:0] OFF_CTL_C = 8'h08;
   localparam logic [7:0] OFF_CTL_D = 8'h0c;
   localparam logic [7:0] OFF_DIR_A = 8'h10;
   localparam logic [7:0] OFF_DIR_B = 8'h14;
   localparam logic [7:0] OFF_DIR_C = 8'h18;
   localparam logic [7:0] OFF_DIR_D = 8'h1c;
   localparam logic [7:0] OFF_OUT_A = 8'h20;
   localparam logic [7:0] OFF_OUT_B = 8'h24;
   localparam logic [7:0] OFF_OUT_C = 8'h28;
   localparam logic [7:0] OFF_OUT_D = 8'h2c;
   localparam logic [7:0] OFF_IN_A = 8'h30;
   localparam logic [7:0] OFF_IN_B = 8'h34;
   localparam logic [7:0] OFF_IN_C = 8'h38;
   localparam logic [7:0] OFF_IN_D = 8'h3c;
   localparam logic [7:0] OFF_INTEN_A = 8'h40;
   localparam logic [7:0] OFF_CHIPCFG = 8'h44;
   localparam logic [7:0] OFF_STRAP = 8'h48;
   // chip config field positions
   localparam int CFG_PAS_BIT = 0;
   localparam int CFG_PDS_BIT = 1;
   // strap field positions
   localparam int STRAP_BOOT_LO = 0;
   localparam int STRAP_HBW_BIT = 4;
   // reset value of every control register
   localparam logic [31:0] RST_VAL = 32'h0000_0000;
   // implemented line masks
   localparam logic [31:0] IMPL_A = 32'h3fff_ffff;
   localparam logic [31:0] IMPL_B = 32'h0000_7fff;
   localparam logic [31:0] IMPL_C = 32'h0000_ffff;
   localparam logic [31:0] IMPL_D_OLD = 32'h0000_0074;
   localparam logic [31:0] IMPL_D_NEW = 32'h0000_01f4;
   // general purpose capable line masks
   localparam logic [31:0] GP_A = 32'h3ffb_ffff;
   localparam logic [31:0] GP_B_OLD = 32'h0000_0000;
   localparam logic [31:0] GP_B_NEW = 32'h0000_0800;
   localparam logic [31:0] GP_C_OLD = 32'h0000_c0ff;
   localparam logic [31:0] GP_C_NEW = 32'h0000_c8ff;
   localparam logic [31:0] GP_D_OLD = 32'h0000_0070;
   localparam logic [31:0] GP_D_NEW = 32'h0000_01f0;
   // maskable interrupt capable lines (port A)
   localparam logic [31:0] IRQ_A = 32'h3ffb_fdbf;
   // non maskable interrupt line position
   localparam int NMI_POS = 18;
   // alternate clock output line on port A
   localparam int CLKOUT_POS = 17;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_RESP = 2'b01
   } psm_wr_t;
endpackage

// *** verification/psm_port_mux_checker.sv ***
// pin level assertions for the port signal multiplexer
module psm_port_mux_checker
   import psm_pkg::*;
#(
   parameter bit NEW_MASK = 1'b1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic powerOnResetn,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] padInA,
   input wire logic [31:0] padOenA,
   input wire logic [31:0] padOenB,
   input wire logic [31:0] padOenD,
   input wire logic [31:0] hwInB,
   input wire logic [31:0] irqLines,
   input wire logic nmiLine,
   input wire logic [3:0] bootSelectStrap,
   input wire logic hostByteWidthStrap
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] upCnt_ff;
   logic [2:0] nxt_upCnt;
   // edges since reset release, held at four to cover the internal sync
   always_comb nxt_upCnt = (upCnt_ff == 3'h4) ? upCnt_ff : upCnt_ff + 3'h1;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) upCnt_ff <= 3'h0;
      else upCnt_ff <= nxt_upCnt;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (upCnt_ff != 3'h4);
   // bus answers come on time and stand
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer not held");
   wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer not held");
   // lines that do not exist stay inert
   unimpl_inert_a: assert property (&padOenA[31:30] && &padOenB[31:15] && hwInB[31:15] == 0)
      else $error("missing line active");
   port_d_lines_a: assert property ((padOenD | (NEW_MASK ? IMPL_D_NEW : IMPL_D_OLD)) == '1)
      else $error("port d line count");
   // interrupt and nmi lines, strap hold
   nmi_fixed_a: assert property (nmiLine == $past(padInA[18]) && padOenA[18])
      else $error("nmi line rerouted");
   irq_capable_a: assert property ((irqLines & ~IRQ_A) == 0)
      else $error("interrupt on wrong line");
   irq_follow_a: assert property ((irqLines & ~$past(padInA)) == 0)
      else $error("interrupt without pad level");
   irq_drive_a: assert property ((irqLines & ~padOenA) == 0)
      else $error("interrupt on driven line");
   strap_hold_a: assert property (powerOnResetn [*8]
      |=> $stable({hostByteWidthStrap, bootSelectStrap})) else $error("strap moved");
   // main scenarios reached
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (|irqLines);
   cover property (!padOenA[17]);
endmodule // psm_port_mux_checker

bind psm_port_mux psm_port_mux_checker #(.NEW_MASK(NEW_MASK)) i_chk (.*);

// *** verification/psm_pad_partner.sv ***
// board side of one port: chip drive wins, else the board level shows
module psm_pad_partner (
   input wire logic [31:0] padOut,
   input wire logic [31:0] padOen,
   input wire logic [31:0] boardVal,
   output logic [31:0] padIn
);
   timeunit 1ns;
   timeprecision 1ps;
   // resolve each line; board holds strap levels through power-on
   assign padIn = (padOut & ~padOen) | (boardVal & padOen);
endmodule // psm_pad_partner

// *** verification/port_signal_multiplexer_bench.sv ***
// self-checking bench for the port signal multiplexer
module port_signal_multiplexer_bench;
   import psm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] PAT = 32'h5a3c_96e1;
   localparam logic [31:0] Q = 32'h0ff4_33cc;
   localparam logic [31:0] GPM [4] = '{GP_A, GP_B_NEW, GP_C_NEW, GP_D_NEW};
   localparam logic [31:0] HWM [3] = '{32'h0003_ffff, IMPL_B, IMPL_C};
   logic clk = 1'b0, resetn = 1'b0, powerOnResetn = 1'b0, altClock = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, brd = PAT;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, irqLines, padInA, padInB, padInC, padInD;
   logic [31:0] padOutA, padOutB, padOutC, padOutD, padOenA, padOenB, padOenC, padOenD;
   logic [31:0] hwInA, hwInB, hwInC, hwInD;
   logic [31:0] hwOutA = '0, hwOutB = '0, hwOutC = '0, hwOutD = '0;
   logic [31:0] hwOeA = '0, hwOeB = '0, hwOeC = '0, hwOeD = '0;
   logic nmiLine, hostByteWidthStrap;
   logic [3:0] bootSelectStrap;
   wire logic [31:0] oen [4];
   wire logic [31:0] pout [4];
   wire logic [31:0] hin [3];
   int mismatches = 0, total_checks = 0;
   assign oen = '{padOenA, padOenB, padOenC, padOenD};
   assign pout = '{padOutA, padOutB, padOutC, padOutD};
   assign hin = '{hwInA, hwInB, hwInC};
   always #10 clk = ~clk;
   psm_port_mux #(.NEW_MASK(1'b1)) i_dut (.*);
   psm_pad_partner i_brdA (.padOut(padOutA), .padOen(padOenA), .boardVal(brd), .padIn(padInA));
   psm_pad_partner i_brdB (.padOut(padOutB), .padOen(padOenB), .boardVal(brd), .padIn(padInB));
   psm_pad_partner i_brdC (.padOut(padOutC), .padOen(padOenC), .boardVal(brd), .padIn(padInC));
   psm_pad_partner i_brdD (.padOut(padOutD), .padOen(padOenD), .boardVal(brd), .padIn(padInD));
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // bus write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      @(posedge clk);
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (aw && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (w && s_axi_wready) s_axi_wvalid <= 1'b0;
         aw = aw && !s_axi_awready;
         w = w && !s_axi_wready;
      end while (aw || w || !s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY}, "write response");
      @(posedge clk); // pads and inputs follow one edge after the write
   endtask
   // bus read with expected data and response
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, string what);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk({30'h0, s_axi_rresp}, {30'h0, er}, what);
      if (er === RESP_OKAY) chk(s_axi_rdata, e, what);
   endtask
   // reset state, pad inputs and straps
   task automatic t_reset();
      for (int p = 0; p < 4; p++) begin
         chk(oen[p], '1, "idle enable");
         rd(OFF_CTL_A + 8'(4 * p), '0, RESP_OKAY, "control reset");
         rd(OFF_DIR_A + 8'(4 * p), '0, RESP_OKAY, "direction reset");
         rd(OFF_IN_A + 8'(4 * p), PAT & GPM[p], RESP_OKAY, "input level");
      end
      rd(OFF_INTEN_A, '0, RESP_OKAY, "enable reset");
      rd(OFF_CHIPCFG, '0, RESP_OKAY, "select reset");
      rd(OFF_STRAP, {27'h0, PAT[2], PAT[8], PAT[7], PAT[15], PAT[14]}, RESP_OKAY, "straps");
      $display("reset test done");
   endtask
   // software output on every port
   task automatic t_gpo();
      for (int p = 0; p < 4; p++) begin
         wr(OFF_OUT_A + 8'(4 * p), ~PAT);
         wr(OFF_DIR_A + 8'(4 * p), '1);
         chk(oen[p], ~GPM[p], "output enable");
         chk(pout[p] & GPM[p], ~PAT & GPM[p], "output level");
         rd(OFF_IN_A + 8'(4 * p), '0, RESP_OKAY, "input while driving");
         wr(OFF_DIR_A + 8'(4 * p), '0);
      end
      $display("output test done");
   endtask
   // interrupt inputs and what disables them
   task automatic t_irq();
      wr(OFF_INTEN_A, '1);
      chk(irqLines, PAT & IRQ_A, "interrupt lines");
      chk({31'h0, nmiLine}, {31'h0, PAT[18]}, "nmi level");
      rd(OFF_IN_A, PAT & GP_A & ~IRQ_A, RESP_OKAY, "input beside interrupts");
      wr(OFF_DIR_A, '1);
      chk(irqLines, '0, "interrupt under output");
      wr(OFF_DIR_A, '0);
      wr(OFF_CTL_A, '1);
      chk(irqLines, '0, "interrupt under peripheral");
      $display("interrupt test done");
   endtask
   // peripheral, alternate clock and strap hold
   task automatic t_hw();
      hwOutA <= ~PAT;
      hwOutB <= ~PAT;
      hwOutC <= ~PAT;
      hwOeA <= Q;
      hwOeB <= Q;
      hwOeC <= Q;
      wr(OFF_CTL_B, '1);
      wr(OFF_CTL_C, '1);
      @(posedge clk);
      for (int p = 0; p < 3; p++) begin
         chk(oen[p] & HWM[p], ~Q & HWM[p], "peripheral enable");
         chk(pout[p] & HWM[p], ~PAT & HWM[p], "peripheral level");
         chk(hin[p] & HWM[p], (PAT ^ Q) & HWM[p], "peripheral input");
      end
      wr(OFF_CHIPCFG, 32'h1);
      chk({padOutA[17], padOenA[17]}, 32'h0, "clock out low");
      altClock <= 1'b1;
      repeat (2) @(posedge clk);
      chk({31'h0, padOutA[17]}, 32'h1, "clock out high");
      wr(OFF_CTL_A, 32'hfffd_ffff);
      chk({31'h0, padOenA[17]}, 32'h1, "clock out needs peripheral mode");
      wr(OFF_CHIPCFG, 32'h3);
      rd(OFF_CHIPCFG, 32'h3, RESP_OKAY, "select bits");
      rd(8'h80, '0, RESP_SLVERR, "unmapped read");
      brd <= ~PAT;
      repeat (4) @(posedge clk);
      chk({27'h0, hostByteWidthStrap, bootSelectStrap},
         {27'h0, PAT[2], PAT[8], PAT[7], PAT[15], PAT[14]}, "strap hold");
      $display("peripheral test done");
   endtask
   // counts and verdict
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // reset, power-on strap capture, then the tests
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      powerOnResetn <= 1'b1;
      repeat (8) @(posedge clk);
      t_reset();
      t_gpo();
      t_irq();
      t_hw();
      print_verdict();
   end
   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      print_verdict();
   end
endmodule // port_signal_multiplexer_bench
